// File: logic/irq_pkg.sv
package irq_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int APB_ADDR_W = 10;
  localparam logic [7:0] IDX_TIMER_EXTINT_CONTROL = 8'h88;
  localparam logic [7:0] IDX_INTERRUPT_ENABLE_THIRD = 8'h9A;
  localparam logic [7:0] IDX_INTERRUPT_ENABLE_FIRST = 8'hA8;
  localparam logic [7:0] IDX_INTERRUPT_ENABLE_SECOND = 8'hB8;
  localparam logic [7:0] IDX_INTERRUPT_REQUEST_FLAGS = 8'hC0;
  localparam logic [7:0] IDX_TIMER2_CONTROL = 8'hC8;
  localparam logic [7:0] IDX_COMPARE_TIMER_CONTROL = 8'hE1;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int TEC_EXT0_TYPE = 0;
  localparam int TEC_EXT0_REQ = 1;
  localparam int TEC_EXT1_TYPE = 2;
  localparam int TEC_EXT1_REQ = 3;
  localparam int TEC_T0_OVF = 5;
  localparam int TEC_T1_OVF = 7;
  localparam int EN0_GLOBAL = 7;
  localparam int EN1_RELOAD = 7;
  localparam int EN2_SERB = 0;
  localparam int EN2_CMP_TIMER = 3;
  localparam int IRQF_CONV = 0;
  localparam int IRQF_EXT2 = 1;
  localparam int IRQF_EXT3 = 2;
  localparam int IRQF_EXT4 = 3;
  localparam int IRQF_EXT5 = 4;
  localparam int IRQF_EXT6 = 5;
  localparam int IRQF_T2_OVF = 6;
  localparam int IRQF_RELOAD = 7;
  localparam int T2C_EXT2_POL = 5;
  localparam int T2C_EXT3_POL = 6;
  localparam int CTC_CMP_OVF = 3;
  localparam int PIN_RELOAD = 7;

  // ---------------------------------------------------------------
  // interrupt sources, in the order of the pending vector
  // ---------------------------------------------------------------
  localparam int NUM_SRC = 14;
  localparam int SRC_EXT0 = 0;
  localparam int SRC_T0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_T1 = 3;
  localparam int SRC_SERA = 4;
  localparam int SRC_T2 = 5;
  localparam int SRC_CONV = 6;
  localparam int SRC_EXT2 = 7;
  localparam int SRC_EXT3 = 8;
  localparam int SRC_EXT5 = 10;
  localparam int SRC_SERB = 12;
  localparam int SRC_CMP_TIMER = 13;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] PIN_IDLE = 8'hFF;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic timer0_overflow;
    logic timer1_overflow;
    logic timer2_overflow;
    logic serial_a_rx_flag;
    logic serial_a_tx_flag;
    logic serial_b_rx_flag;
    logic serial_b_tx_flag;
    logic converter_done;
    logic [3:0] compare_event;
    logic compare_channel_4;
    logic cmp_timer_rollover;
  } periph_event_type;

  typedef struct packed {
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
    logic [7:0] pin_prev;
    logic [7:0] timer_extint_control;
    logic [7:0] interrupt_enable_first;
    logic [7:0] interrupt_enable_second;
    logic [7:0] interrupt_enable_third;
    logic [7:0] interrupt_request_flags;
    logic [7:0] timer2_control;
    logic [7:0] compare_timer_control;
    logic [NUM_SRC-1:0] pending;
    logic reload_strobe;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } state_type;

endpackage : irq_pkg

// File: logic/interrupt_request_enable_logic.sv
// Functional notes
// - global enable zero blocks every source; one lets individual enables decide
// - first enable register at 0A8H: global, spare, t2, serial a, t1, ext1, t0, ext0
// - second enable register at 0B8H: converter, ext2..ext6, reload interrupt enables
// - third enable register at 09AH: serial b and compare timer enables
// - reload enable masks only the reload request, never the reload action
// - ext0/ext1 type bit: one is falling edge, zero is low level
// - edge mode flag set on fall, cleared on vector; level mode follows pin
// - timer 0/1 overflow flags set on rollover, cleared on vector
// - serial rx and tx flags ORed per channel, never cleared on vector
// - timer 2 request is overflow OR reload flag, no clear on vector
// - converter flag set per conversion before result valid, software clears
// - ext2 flag set on rising edge if polarity one, else falling edge
// - ext3 flag set on rising edge if polarity one, else falling edge
// - ext2 flag also set by compare channel 4 event, cleared on vector
// - ext3 flag also set by compare channel 0 event, cleared on vector
// - ext4..6 set on rising edge or compare 1..3 event, cleared on vector
// - compare timer overflow flag set on rollover, software clears only
// - request flag register at 0C0H: reload, t2 ovf, ext6..ext2, converter
// - reload flag set on reload pin fall while reload enable is one
// - compare timer control register at 0E1H has overflow flag in bit 3
// - timer control at 88H holds ext types, ext0/1 flags, timer flags
// - flags set regardless of enable, except the reload flag; a set flag stays set until cleared, except level-mode ext0/ext1 flags
// - software writes flags like hardware, except level-mode ext0/ext1 flags
//
// Added by the designer: register access over APB.
`timescale 1ns/1ns
`default_nettype none

module interrupt_request_enable_logic (
  input wire logic clk,
  input wire logic sys_rst,
  input wire irq_pkg::apb_req_type apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [6:0] ext_irq_pins,
  input wire logic timer2_reload_pin,
  input wire irq_pkg::periph_event_type periph_event,
  input wire logic [irq_pkg::NUM_SRC-1:0] vector_ack,
  output logic [irq_pkg::NUM_SRC-1:0] irq_pending,
  output logic reload_strobe
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic reg_hit(input logic [irq_pkg::APB_ADDR_W-1:0] addr,
                                   input logic [7:0] index);
    return addr == {index, 2'b00};
  endfunction : reg_hit

  // a hardware set beats both a vector clear and a software write
  function automatic logic flag_next(input logic old, input logic wr_hit,
                                     input logic wbit, input logic clr,
                                     input logic set);
    return set | (wr_hit ? wbit : (old & ~clr));
  endfunction : flag_next

  irq_pkg::state_type state_reg;
  irq_pkg::state_type state_next;

  logic [7:0] fall;
  logic [7:0] rise;
  logic access;
  logic wr_go;
  logic hit_tec;
  logic hit_en1st;
  logic hit_en2nd;
  logic hit_en3rd;
  logic hit_irqf;
  logic hit_t2c;
  logic hit_ctc;
  logic mapped;
  logic w_tec;
  logic w_irqf;
  logic w_ctc;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic [irq_pkg::NUM_SRC-1:0] req;
  logic [irq_pkg::NUM_SRC-1:0] en;
  logic ext2_edge;
  logic ext3_edge;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;

    // the first stage feeds only the second
    state_next.pin_meta = {timer2_reload_pin, ext_irq_pins};
    state_next.pin_sync = state_reg.pin_meta;
    state_next.pin_prev = state_reg.pin_sync;
    fall = state_reg.pin_prev & ~state_reg.pin_sync;
    rise = ~state_reg.pin_prev & state_reg.pin_sync;

    // apb: one wait state, write lands on the edge that samples pready
    access = apb_req.psel & apb_req.penable;
    wr_go = access & apb_req.pwrite & state_reg.pready;
    hit_tec = reg_hit(apb_req.paddr, irq_pkg::IDX_TIMER_EXTINT_CONTROL);
    hit_en1st = reg_hit(apb_req.paddr, irq_pkg::IDX_INTERRUPT_ENABLE_FIRST);
    hit_en2nd = reg_hit(apb_req.paddr, irq_pkg::IDX_INTERRUPT_ENABLE_SECOND);
    hit_en3rd = reg_hit(apb_req.paddr, irq_pkg::IDX_INTERRUPT_ENABLE_THIRD);
    hit_irqf = reg_hit(apb_req.paddr, irq_pkg::IDX_INTERRUPT_REQUEST_FLAGS);
    hit_t2c = reg_hit(apb_req.paddr, irq_pkg::IDX_TIMER2_CONTROL);
    hit_ctc = reg_hit(apb_req.paddr, irq_pkg::IDX_COMPARE_TIMER_CONTROL);
    mapped = hit_tec | hit_en1st | hit_en2nd | hit_en3rd | hit_irqf | hit_t2c | hit_ctc;
    w_tec = wr_go & hit_tec;
    w_irqf = wr_go & hit_irqf;
    w_ctc = wr_go & hit_ctc;
    wbyte = apb_req.pwdata[7:0];

    rbyte = irq_pkg::REG_RESET;
    if (hit_tec) begin
      rbyte = state_reg.timer_extint_control;
    end else if (hit_en1st) begin
      rbyte = state_reg.interrupt_enable_first;
    end else if (hit_en2nd) begin
      rbyte = state_reg.interrupt_enable_second;
    end else if (hit_en3rd) begin
      rbyte = state_reg.interrupt_enable_third;
    end else if (hit_irqf) begin
      rbyte = state_reg.interrupt_request_flags;
    end else if (hit_t2c) begin
      rbyte = state_reg.timer2_control;
    end else if (hit_ctc) begin
      rbyte = state_reg.compare_timer_control;
    end

    state_next.pready = access & ~state_reg.pready;
    state_next.pslverr = access & ~state_reg.pready & ~mapped;
    if (access && !state_reg.pready && !apb_req.pwrite) begin
      state_next.prdata = {24'h000000, rbyte};
    end

    // enable registers are plain storage
    if (wr_go && hit_en1st) begin
      state_next.interrupt_enable_first = wbyte;
    end
    if (wr_go && hit_en2nd) begin
      state_next.interrupt_enable_second = wbyte;
    end
    if (wr_go && hit_en3rd) begin
      state_next.interrupt_enable_third = wbyte;
    end
    if (wr_go && hit_t2c) begin
      state_next.timer2_control = wbyte;
    end

    // non-flag bits of the mixed registers take the write as is
    if (w_tec) begin
      state_next.timer_extint_control = wbyte;
    end
    if (w_ctc) begin
      state_next.compare_timer_control = wbyte;
    end

    // timer control flags
    state_next.timer_extint_control[irq_pkg::TEC_T0_OVF] = flag_next(
      state_reg.timer_extint_control[irq_pkg::TEC_T0_OVF], w_tec, wbyte[irq_pkg::TEC_T0_OVF],
      vector_ack[irq_pkg::SRC_T0], periph_event.timer0_overflow);
    state_next.timer_extint_control[irq_pkg::TEC_T1_OVF] = flag_next(
      state_reg.timer_extint_control[irq_pkg::TEC_T1_OVF], w_tec, wbyte[irq_pkg::TEC_T1_OVF],
      vector_ack[irq_pkg::SRC_T1], periph_event.timer1_overflow);

    // level mode ignores writes: the pin owns the flag
    if (state_reg.timer_extint_control[irq_pkg::TEC_EXT0_TYPE]) begin
      state_next.timer_extint_control[irq_pkg::TEC_EXT0_REQ] = flag_next(
        state_reg.timer_extint_control[irq_pkg::TEC_EXT0_REQ], w_tec,
        wbyte[irq_pkg::TEC_EXT0_REQ], vector_ack[irq_pkg::SRC_EXT0], fall[0]);
    end else begin
      state_next.timer_extint_control[irq_pkg::TEC_EXT0_REQ] = ~state_reg.pin_sync[0];
    end
    if (state_reg.timer_extint_control[irq_pkg::TEC_EXT1_TYPE]) begin
      state_next.timer_extint_control[irq_pkg::TEC_EXT1_REQ] = flag_next(
        state_reg.timer_extint_control[irq_pkg::TEC_EXT1_REQ], w_tec,
        wbyte[irq_pkg::TEC_EXT1_REQ], vector_ack[irq_pkg::SRC_EXT1], fall[1]);
    end else begin
      state_next.timer_extint_control[irq_pkg::TEC_EXT1_REQ] = ~state_reg.pin_sync[1];
    end

    // request flag register
    ext2_edge = state_reg.timer2_control[irq_pkg::T2C_EXT2_POL] ? rise[2] : fall[2];
    ext3_edge = state_reg.timer2_control[irq_pkg::T2C_EXT3_POL] ? rise[3] : fall[3];
    state_next.interrupt_request_flags[irq_pkg::IRQF_CONV] = flag_next(
      state_reg.interrupt_request_flags[irq_pkg::IRQF_CONV], w_irqf,
      wbyte[irq_pkg::IRQF_CONV], 1'b0, periph_event.converter_done);
    state_next.interrupt_request_flags[irq_pkg::IRQF_EXT2] = flag_next(
      state_reg.interrupt_request_flags[irq_pkg::IRQF_EXT2], w_irqf,
      wbyte[irq_pkg::IRQF_EXT2], vector_ack[irq_pkg::SRC_EXT2],
      ext2_edge | periph_event.compare_channel_4);
    state_next.interrupt_request_flags[irq_pkg::IRQF_EXT3] = flag_next(
      state_reg.interrupt_request_flags[irq_pkg::IRQF_EXT3], w_irqf,
      wbyte[irq_pkg::IRQF_EXT3], vector_ack[irq_pkg::SRC_EXT3],
      ext3_edge | periph_event.compare_event[0]);
    for (int i = 0; i < 3; i++) begin
      state_next.interrupt_request_flags[irq_pkg::IRQF_EXT4 + i] = flag_next(
        state_reg.interrupt_request_flags[irq_pkg::IRQF_EXT4 + i], w_irqf,
        wbyte[irq_pkg::IRQF_EXT4 + i], vector_ack[irq_pkg::SRC_EXT3 + 1 + i],
        rise[4 + i] | periph_event.compare_event[1 + i]);
    end
    state_next.interrupt_request_flags[irq_pkg::IRQF_T2_OVF] = flag_next(
      state_reg.interrupt_request_flags[irq_pkg::IRQF_T2_OVF], w_irqf,
      wbyte[irq_pkg::IRQF_T2_OVF], 1'b0, periph_event.timer2_overflow);
    state_next.interrupt_request_flags[irq_pkg::IRQF_RELOAD] = flag_next(
      state_reg.interrupt_request_flags[irq_pkg::IRQF_RELOAD], w_irqf,
      wbyte[irq_pkg::IRQF_RELOAD], 1'b0,
      fall[irq_pkg::PIN_RELOAD] &
      state_reg.interrupt_enable_second[irq_pkg::EN1_RELOAD]);

    // reload action runs whatever the reload interrupt enable says
    state_next.reload_strobe = fall[irq_pkg::PIN_RELOAD];

    state_next.compare_timer_control[irq_pkg::CTC_CMP_OVF] = flag_next(
      state_reg.compare_timer_control[irq_pkg::CTC_CMP_OVF], w_ctc,
      wbyte[irq_pkg::CTC_CMP_OVF], 1'b0, periph_event.cmp_timer_rollover);

    // pending vector seen by the sequencer
    req = {state_reg.compare_timer_control[irq_pkg::CTC_CMP_OVF],
           periph_event.serial_b_rx_flag | periph_event.serial_b_tx_flag,
           state_reg.interrupt_request_flags[5:0],
           state_reg.interrupt_request_flags[irq_pkg::IRQF_T2_OVF] |
           state_reg.interrupt_request_flags[irq_pkg::IRQF_RELOAD],
           periph_event.serial_a_rx_flag | periph_event.serial_a_tx_flag,
           state_reg.timer_extint_control[irq_pkg::TEC_T1_OVF],
           state_reg.timer_extint_control[irq_pkg::TEC_EXT1_REQ],
           state_reg.timer_extint_control[irq_pkg::TEC_T0_OVF],
           state_reg.timer_extint_control[irq_pkg::TEC_EXT0_REQ]};
    en = {state_reg.interrupt_enable_third[irq_pkg::EN2_CMP_TIMER],
          state_reg.interrupt_enable_third[irq_pkg::EN2_SERB],
          state_reg.interrupt_enable_second[5:0],
          state_reg.interrupt_enable_first[5:0]};
    state_next.pending = req & en &
      {irq_pkg::NUM_SRC{state_reg.interrupt_enable_first[irq_pkg::EN0_GLOBAL]}};
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= '0;
      // idle-high pins so reset release does not fake a falling edge
      state_reg.pin_meta <= irq_pkg::PIN_IDLE;
      state_reg.pin_sync <= irq_pkg::PIN_IDLE;
      state_reg.pin_prev <= irq_pkg::PIN_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign irq_pending = state_reg.pending;
  assign reload_strobe = state_reg.reload_strobe;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  a_global_gate:
    assert property (!state_reg.interrupt_enable_first[irq_pkg::EN0_GLOBAL]
                     |=> state_reg.pending == '0)
    else $error("pending raised while global enable was clear");

  a_pending_cause:
    assert property (state_reg.pending[irq_pkg::SRC_T0]
                     |-> $past(state_reg.timer_extint_control[irq_pkg::TEC_T0_OVF]
                               && state_reg.interrupt_enable_first[irq_pkg::SRC_T0]
                               && state_reg.interrupt_enable_first[irq_pkg::EN0_GLOBAL]))
    else $error("timer 0 pending without flag and enables");

  a_timer0_clear:
    assert property (vector_ack[irq_pkg::SRC_T0] && !periph_event.timer0_overflow && !w_tec
                     |=> !state_reg.timer_extint_control[irq_pkg::TEC_T0_OVF])
    else $error("timer 0 flag survived its vector");

  a_ext0_level:
    assert property (!state_reg.timer_extint_control[irq_pkg::TEC_EXT0_TYPE]
                     |=> state_reg.timer_extint_control[irq_pkg::TEC_EXT0_REQ]
                         == !$past(state_reg.pin_sync[0]))
    else $error("level mode flag does not follow pin");

  a_ext4_rise:
    assert property (!ext_irq_pins[4] ##1 ext_irq_pins[4] [*3]
                     |=> state_reg.interrupt_request_flags[irq_pkg::IRQF_EXT4])
    else $error("ext4 rising edge lost");

  a_ext5_clear:
    assert property (vector_ack[irq_pkg::SRC_EXT5] && !rise[5]
                     && !periph_event.compare_event[2] && !w_irqf
                     |=> !state_reg.interrupt_request_flags[irq_pkg::IRQF_EXT5])
    else $error("ext5 flag survived its vector");

  a_ext2_polarity:
    assert property (fall[2] && !state_reg.timer2_control[irq_pkg::T2C_EXT2_POL]
                     |=> state_reg.interrupt_request_flags[irq_pkg::IRQF_EXT2])
    else $error("ext2 falling edge lost");

  a_cmp0_event:
    assert property (periph_event.compare_event[0]
                     |=> state_reg.interrupt_request_flags[irq_pkg::IRQF_EXT3])
    else $error("compare 0 event did not set ext3 flag");

  a_conv_sticky:
    assert property (state_reg.interrupt_request_flags[irq_pkg::IRQF_CONV] && !w_irqf
                     |=> state_reg.interrupt_request_flags[irq_pkg::IRQF_CONV])
    else $error("converter flag cleared without software");

  a_reload_gated:
    assert property (fall[irq_pkg::PIN_RELOAD]
                     && !state_reg.interrupt_enable_second[irq_pkg::EN1_RELOAD]
                     && !state_reg.interrupt_request_flags[irq_pkg::IRQF_RELOAD] && !w_irqf
                     |=> !state_reg.interrupt_request_flags[irq_pkg::IRQF_RELOAD]
                         && state_reg.reload_strobe)
    else $error("reload enable misused");

  a_cmp_timer:
    assert property (periph_event.cmp_timer_rollover
                     |=> state_reg.compare_timer_control[irq_pkg::CTC_CMP_OVF])
    else $error("compare timer rollover lost");

  a_serial_or:
    assert property (state_reg.pending[irq_pkg::SRC_SERA]
                     |-> $past(periph_event.serial_a_rx_flag || periph_event.serial_a_tx_flag))
    else $error("serial a pending without a flag");

  a_t1_clear:
    assert property (vector_ack[irq_pkg::SRC_T1] && !periph_event.timer1_overflow && !w_tec
                     |=> !state_reg.timer_extint_control[irq_pkg::TEC_T1_OVF])
    else $error("timer 1 flag survived its vector");

  a_ext0_edge_set:
    assert property (state_reg.timer_extint_control[irq_pkg::TEC_EXT0_TYPE] && fall[0]
                     |=> state_reg.timer_extint_control[irq_pkg::TEC_EXT0_REQ])
    else $error("ext0 falling edge lost in edge mode");

  a_ext0_edge_clear:
    assert property (state_reg.timer_extint_control[irq_pkg::TEC_EXT0_TYPE]
                     && vector_ack[irq_pkg::SRC_EXT0] && !fall[0] && !w_tec
                     |=> !state_reg.timer_extint_control[irq_pkg::TEC_EXT0_REQ])
    else $error("ext0 edge flag survived its vector");

  a_t2_no_clear:
    assert property (state_reg.interrupt_request_flags[irq_pkg::IRQF_T2_OVF] && !w_irqf
                     |=> state_reg.interrupt_request_flags[irq_pkg::IRQF_T2_OVF])
    else $error("timer 2 flag cleared without software");

  a_reload_set:
    assert property (fall[irq_pkg::PIN_RELOAD]
                     && state_reg.interrupt_enable_second[irq_pkg::EN1_RELOAD]
                     |=> state_reg.interrupt_request_flags[irq_pkg::IRQF_RELOAD]
                         && state_reg.reload_strobe)
    else $error("reload edge lost while reload enable set");

  a_ext3_rise:
    assert property (rise[3] && state_reg.timer2_control[irq_pkg::T2C_EXT3_POL]
                     |=> state_reg.interrupt_request_flags[irq_pkg::IRQF_EXT3])
    else $error("ext3 rising edge lost");

  a_ext2_compare:
    assert property (periph_event.compare_channel_4
                     |=> state_reg.interrupt_request_flags[irq_pkg::IRQF_EXT2])
    else $error("compare 4 event did not set ext2 flag");

  a_cmp_sticky:
    assert property (state_reg.compare_timer_control[irq_pkg::CTC_CMP_OVF] && !w_ctc
                     |=> state_reg.compare_timer_control[irq_pkg::CTC_CMP_OVF])
    else $error("compare timer flag cleared without software");

  a_apb_wait: 
    assert property (access && !state_reg.pready |=> state_reg.pready)
    else $error("apb access not answered after one wait");

endmodule : interrupt_request_enable_logic

`default_nettype wire

// File: verif/cpu_seq_model.sv
`timescale 1ns/1ns
`default_nettype none

module cpu_seq_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [irq_pkg::NUM_SRC-1:0] irq_pending,
  input wire logic [irq_pkg::NUM_SRC-1:0] ack_mask,
  output logic [irq_pkg::NUM_SRC-1:0] vector_ack
);
  // ---------------------------------------------------------------
  // round-robin vectoring
  // ---------------------------------------------------------------
  // a fixed scan, so sources that stay pending cannot starve higher bits
  logic [3:0] ptr_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ptr_reg <= 4'h0;
      vector_ack <= '0;
    end else begin
      ptr_reg <= (ptr_reg == 4'hD) ? 4'h0 : ptr_reg + 4'h1;
      vector_ack <= '0;
      if (irq_pending[ptr_reg] && ack_mask[ptr_reg]) vector_ack[ptr_reg] <= 1'b1;
    end
  end
endmodule : cpu_seq_model

`default_nettype wire

// File: verif/tb_interrupt_request_enable_logic.sv
`timescale 1ns/1ns
`default_nettype none

module tb_interrupt_request_enable_logic;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  irq_pkg::apb_req_type req = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [6:0] pins = 7'h7F;
  logic rl_pin = 1'b1;
  irq_pkg::periph_event_type ev = '0;
  logic [13:0] ack;
  logic [13:0] mask = '0;
  logic [13:0] pend;
  logic strobe;
  logic [8:0] q[$];
  logic [8:0] e;
  logic [7:0] rnd;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_strobe = 0;
  int seed = 30;
  logic [7:0] regs [7] = '{irq_pkg::IDX_TIMER_EXTINT_CONTROL, irq_pkg::IDX_INTERRUPT_ENABLE_FIRST,
    irq_pkg::IDX_INTERRUPT_ENABLE_SECOND, irq_pkg::IDX_INTERRUPT_ENABLE_THIRD,
    irq_pkg::IDX_INTERRUPT_REQUEST_FLAGS, irq_pkg::IDX_TIMER2_CONTROL,
    irq_pkg::IDX_COMPARE_TIMER_CONTROL};

  interrupt_request_enable_logic u_dut (.clk(clk), .sys_rst(sys_rst), .apb_req(req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_irq_pins(pins),
    .timer2_reload_pin(rl_pin), .periph_event(ev), .vector_ack(ack),
    .irq_pending(pend), .reload_strobe(strobe));

  cpu_seq_model u_cpu (.clk(clk), .sys_rst(sys_rst), .irq_pending(pend), .ack_mask(mask),
    .vector_ack(ack));

  initial begin
    forever #25 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [32:0] ex, input logic [32:0] s);
    n_checks++;
    if (s !== ex) begin
      $display("ERROR %s expected %h seen %h", nm, ex, s);
      n_mismatch++;
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     input logic [8:0] ex);
    int n;
    n = 0;
    @(posedge clk);
    req <= {1'b1, 1'b0, w, idx, 2'b00, 24'h0, d};
    if (!w) q.push_back(ex);
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    req <= '0;
    if (n >= 20) chk("pready", 33'h1, 33'h0);
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 9'h000);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b0, idx, 8'h00, {1'b0, d});
  endtask : rd

  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask : w

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  // ---------------------------------------------------------------
  // monitor: read answers against the oldest note
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (strobe === 1'b1) n_strobe <= n_strobe + 1;
    if (pready === 1'b1 && req.psel === 1'b1 && req.pwrite === 1'b0) begin
      e = (q.size() > 0) ? q.pop_front() : 9'h1FF;
      chk("prdata", {e[8], 24'h0, e[7:0]}, {pslverr, prdata});
    end
  end

  initial begin
    #500000;
    n_mismatch++;
    summarize();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 7; i++) rd(regs[i], 8'h00);
    apb(1'b0, 8'h00, 8'h00, 9'h100);
    for (int i = 1; i < 7; i++) begin
      rnd = 8'($random(seed));
      wr(regs[i], rnd);
      rd(regs[i], rnd);
      wr(regs[i], 8'h00);
    end
    // every event at once, enables still off
    ev <= '1;
    @(posedge clk);
    ev <= 14'h0480;
    w(4);
    rd(regs[0], 8'hA0);
    rd(regs[4], 8'h7F);
    rd(regs[6], 8'h08);
    wr(regs[1], 8'h7F);
    wr(regs[2], 8'h7F);
    wr(regs[3], 8'h09);
    w(3);
    chk("irq_pending", 33'h0, {19'h0, pend});
    wr(regs[1], 8'hFF);
    w(3);
    chk("irq_pending", 33'h3FFA, {19'h0, pend});
    mask <= '1;
    w(60);
    mask <= '0;
    chk("irq_pending", 33'h3070, {19'h0, pend});
    ev <= '0;
    wr(regs[4], 8'h00);
    wr(regs[6], 8'h00);
    // ext0 edge mode, ext1 level mode
    wr(regs[0], 8'h01);
    wr(regs[0], 8'h01);
    pins <= 7'h7E;
    w(6);
    rd(regs[0], 8'h03);
    pins <= 7'h7F;
    mask <= 14'h0001;
    w(20);
    mask <= '0;
    rd(regs[0], 8'h01);
    pins <= 7'h7D;
    mask <= 14'h0004;
    w(20);
    mask <= '0;
    rd(regs[0], 8'h09);
    pins <= 7'h7F;
    w(6);
    wr(regs[0], 8'h09);
    rd(regs[0], 8'h01);
    // ext2 rising, ext3 falling, ext4..6 rising
    wr(regs[5], 8'h20);
    pins <= 7'h03;
    w(6);
    rd(regs[4], 8'h04);
    pins <= 7'h7F;
    w(6);
    rd(regs[4], 8'h3E);
    // opposite polarities: ext2 falling, ext3 rising
    wr(regs[4], 8'h00);
    wr(regs[5], 8'h40);
    pins <= 7'h03;
    w(6);
    rd(regs[4], 8'h02);
    pins <= 7'h7F;
    w(6);
    rd(regs[4], 8'h3E);
    wr(regs[4], 8'h00);
    rl_pin <= 1'b0;
    w(6);
    rl_pin <= 1'b1;
    w(6);
    rd(regs[4], 8'h00);
    wr(regs[2], 8'h80);
    rl_pin <= 1'b0;
    w(6);
    rd(regs[4], 8'h80);
    chk("reload_strobe", 33'd2, 33'(n_strobe));
    summarize();
  end
endmodule : tb_interrupt_request_enable_logic

`default_nettype wire
